/* rtl/twi_pkg.sv */
// Purpose: shared constants and types for the trap and wake interrupt block
// Assumes: APB slave, 32-bit data, one instruction clock
// Notes: register offsets are byte addresses
package twi_pkg;
    localparam logic [7:0] OFF_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] OFF_WAKE_EDGE = 8'h04;
    localparam logic [7:0] OFF_WAKE_PENDING = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam int CTL_GIE_BIT = 0;
    localparam int CTL_GROUP_EN_BIT = 1;
    localparam int CTL_EXT_EN_BIT = 2;
    localparam int CTL_EXT_POL_BIT = 3;
    localparam int CTL_EXT_PEND_BIT = 4;
    localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] RST_WAKE_EDGE = 8'h00;
    localparam logic [7:0] RST_WAKE_PENDING = 8'h00;
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [7:0] VEC_TRAP = 8'hfe;
    localparam logic [7:0] VEC_EXT = 8'hfa;
    localparam logic [7:0] VEC_WAKE = 8'he2;
    localparam logic [7:0] VEC_DEFAULT = 8'he0;
    localparam logic [14:0] STACK_UNDERFLOW_PC = 15'h7fff;
    localparam logic [7:0] STACK_LIMIT = 8'h6f;

    typedef enum logic [1:0] {TWI_IDLE, TWI_IN_MASKABLE, TWI_IN_TRAP} twi_ctx_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } twi_apb_req_s;

    typedef struct packed {
        logic fetch_valid;
        logic [7:0] fetch_opcode;
        logic fetch_in_range;
        logic [14:0] fetch_pc;
        logic clear_trap_pending_instr;
        logic vector_select_instr;
        logic return_from_irq_instr;
        logic return_and_skip_instr;
        logic stack_pop;
        logic [7:0] stack_ptr;
    } twi_seq_s;

    typedef struct packed {
        logic trap_pending_flag;
        twi_ctx_e ctx;
        logic global_irq_enable;
        logic wake_port_group_enable;
        logic ext_irq_enable;
        logic ext_irq_polarity;
        logic ext_irq_pending;
        logic ext_pin_last;
        logic [7:0] wake_enable_reg;
        logic [7:0] wake_edge_reg;
        logic [7:0] wake_pending_reg;
        logic [7:0] wake_pin_last;
        logic [31:0] prdata;
        logic [7:0] vector_low;
        logic vector_valid;
        logic [14:0] return_addr;
        logic push_valid;
        logic pc_load_valid;
        logic [14:0] pc_load_value;
        logic trap_ack;
        logic resume_after_halt;
    } twi_state_s;
endpackage

/* rtl/twi_trap_wake_irq.sv */
// Purpose: trap pending flag, maskable gating, wake port edge interrupts, vector select
// Assumes: sequencer pulses for one cycle per executed instruction, pins synchronous
// Notes: APB slave with zero wait states, unmapped reads return zero
//
// Added by the designer: the register offsets and the APB interface to the registers.
module twi_trap_wake_irq #(
    parameter int WAKE_PINS = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire twi_pkg::twi_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire twi_pkg::twi_seq_s seq,
    input wire logic [7:0] prog_mem_data,
    input wire logic [WAKE_PINS-1:0] wake_pins,
    input wire logic ext_pin,
    input wire logic halted,
    output logic [7:0] fetched_opcode,
    output logic trap_ack,
    output logic irq_request,
    output logic [7:0] vector_low,
    output logic vector_valid,
    output logic [14:0] return_addr,
    output logic push_valid,
    output logic pc_load_valid,
    output logic [14:0] pc_load_value,
    output logic resume_after_halt,
    output logic global_irq_enable
);
    twi_pkg::twi_state_s st_reg;
    twi_pkg::twi_state_s st_next;
    logic wr;
    logic rd;
    logic trap_now;
    logic ext_edge;
    logic [WAKE_PINS-1:0] wake_edge;
    logic wake_active;
    logic ext_active;
    logic mask_ok;
    logic [31:0] wmask;

    function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
        edge_hit = rising ? (!prev && cur) : (prev && !cur);
    endfunction

    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && !apb_req.pwrite;
    assign wmask = apb_req.pwdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    assign fetched_opcode = seq.fetch_in_range ? prog_mem_data : twi_pkg::TRAP_OPCODE;

    assign trap_now = seq.fetch_valid && (fetched_opcode == twi_pkg::TRAP_OPCODE);

    assign ext_edge = edge_hit(st_reg.ext_pin_last, ext_pin, st_reg.ext_irq_polarity);

    genvar gi;
    generate
        for (gi = 0; gi < WAKE_PINS; gi++)
        begin : g_wake
            assign wake_edge[gi] = edge_hit(st_reg.wake_pin_last[gi], wake_pins[gi], st_reg.wake_edge_reg[gi]);
        end
    endgenerate

    // Per pin enable and pending, gated by the group enable
    assign wake_active = |(st_reg.wake_pending_reg & st_reg.wake_enable_reg) && st_reg.wake_port_group_enable;
    assign ext_active = st_reg.ext_irq_enable && st_reg.ext_irq_pending;
    assign mask_ok = !st_reg.trap_pending_flag && st_reg.global_irq_enable && (st_reg.ctx == twi_pkg::TWI_IDLE);
    assign irq_request = mask_ok && (ext_active || wake_active);

    always_comb
    begin
        st_next = st_reg;
        st_next.trap_ack = 1'b0;
        st_next.vector_valid = 1'b0;
        st_next.push_valid = 1'b0;
        st_next.pc_load_valid = 1'b0;
        st_next.resume_after_halt = 1'b0;
        st_next.ext_pin_last = ext_pin;
        st_next.wake_pin_last = wake_pins;
        st_next.prdata = 32'h0000_0000;
        if (rd)
        begin
            case (apb_req.paddr)
                twi_pkg::OFF_WAKE_ENABLE: st_next.prdata = {24'h000000, st_reg.wake_enable_reg};
                twi_pkg::OFF_WAKE_EDGE: st_next.prdata = {24'h000000, st_reg.wake_edge_reg};
                twi_pkg::OFF_WAKE_PENDING: st_next.prdata = {24'h000000, st_reg.wake_pending_reg};
                twi_pkg::OFF_CONTROL: st_next.prdata = {27'h0, st_reg.ext_irq_pending,
                    st_reg.ext_irq_polarity, st_reg.ext_irq_enable, st_reg.wake_port_group_enable,
                    st_reg.global_irq_enable};
                twi_pkg::OFF_STATUS: st_next.prdata = {30'h0, st_reg.ctx};
                default: st_next.prdata = 32'h0000_0000;
            endcase
        end
        if (wr)
        begin
            case (apb_req.paddr)
                twi_pkg::OFF_WAKE_ENABLE: st_next.wake_enable_reg = wmask[7:0];
                twi_pkg::OFF_WAKE_EDGE: st_next.wake_edge_reg = wmask[7:0];
                twi_pkg::OFF_WAKE_PENDING: st_next.wake_pending_reg = st_reg.wake_pending_reg & wmask[7:0];
                twi_pkg::OFF_CONTROL:
                begin
                    st_next.global_irq_enable = wmask[twi_pkg::CTL_GIE_BIT];
                    st_next.wake_port_group_enable = wmask[twi_pkg::CTL_GROUP_EN_BIT];
                    st_next.ext_irq_enable = wmask[twi_pkg::CTL_EXT_EN_BIT];
                    st_next.ext_irq_polarity = wmask[twi_pkg::CTL_EXT_POL_BIT];
                    st_next.ext_irq_pending = st_reg.ext_irq_pending & wmask[twi_pkg::CTL_EXT_PEND_BIT];
                end
                default: st_next.prdata = st_next.prdata;
            endcase
        end
        // Edge sets after clears so an event is never lost
        // Set on selected edge
        st_next.wake_pending_reg = st_next.wake_pending_reg | wake_edge;
        if (ext_edge)
        begin
            st_next.ext_irq_pending = 1'b1;
        end
        // Halt wake with interrupt off resumes
        // Pending latches only after this edge, so test the enables directly
        if (halted && |wake_edge && !irq_request
            && !(mask_ok && st_reg.wake_port_group_enable && |(wake_edge & st_reg.wake_enable_reg)))
        begin
            st_next.resume_after_halt = 1'b1;
        end
        if (seq.clear_trap_pending_instr)
        begin
            st_next.trap_pending_flag = 1'b0;
        end
        if (seq.stack_pop && seq.stack_ptr > twi_pkg::STACK_LIMIT)
        begin
            st_next.pc_load_valid = 1'b1;
            st_next.pc_load_value = twi_pkg::STACK_UNDERFLOW_PC;
        end
        if (seq.return_from_irq_instr)
        begin
            st_next.global_irq_enable = 1'b1;
            st_next.ctx = twi_pkg::TWI_IDLE;
        end
        if (seq.return_and_skip_instr)
        begin
            st_next.ctx = twi_pkg::TWI_IDLE;
        end
        if (irq_request)
        begin
            // Maskable taken clears global enable to block nesting
            st_next.global_irq_enable = 1'b0;
            st_next.ctx = twi_pkg::TWI_IN_MASKABLE;
            st_next.push_valid = 1'b1;
            st_next.return_addr = seq.fetch_pc;
        end
        // Trap sets flag, enable untouched, trap nests
        if (trap_now)
        begin
            st_next.trap_pending_flag = 1'b1;
            st_next.global_irq_enable = st_reg.global_irq_enable;
            st_next.trap_ack = 1'b1;
            st_next.ctx = twi_pkg::TWI_IN_TRAP;
            st_next.push_valid = 1'b1;
            st_next.return_addr = seq.fetch_pc;
        end
        if (seq.vector_select_instr)
        begin
            st_next.vector_valid = 1'b1;
            if (st_reg.trap_pending_flag)
            begin
                st_next.vector_low = twi_pkg::VEC_TRAP;
            end
            // Global enable is already off inside the routine that runs this
            else if (ext_active)
            begin
                st_next.vector_low = twi_pkg::VEC_EXT;
            end
            else if (wake_active)
            begin
                st_next.vector_low = twi_pkg::VEC_WAKE;
            end
            else
            begin
                st_next.vector_low = twi_pkg::VEC_DEFAULT;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            st_reg <= '0;
            st_reg.ctx <= twi_pkg::TWI_IDLE;
            st_reg.wake_enable_reg <= twi_pkg::RST_WAKE_ENABLE;
            st_reg.wake_edge_reg <= twi_pkg::RST_WAKE_EDGE;
            st_reg.wake_pending_reg <= twi_pkg::RST_WAKE_PENDING;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign trap_ack = st_reg.trap_ack;
    assign vector_low = st_reg.vector_low;
    assign vector_valid = st_reg.vector_valid;
    assign return_addr = st_reg.return_addr;
    assign push_valid = st_reg.push_valid;
    assign pc_load_valid = st_reg.pc_load_valid;
    assign pc_load_value = st_reg.pc_load_value;
    assign resume_after_halt = st_reg.resume_after_halt;
    assign global_irq_enable = st_reg.global_irq_enable;

    // Read data registered in setup so it is valid in access
    property p_trap_set;
        @(posedge sys_clk) disable iff (!reset_n) trap_now |=> st_reg.trap_pending_flag && trap_ack;
    endproperty
    a_trap_set: assert property (p_trap_set) else $error("trap flag not set");
    property p_trap_hold;
        @(posedge sys_clk) disable iff (!reset_n)
            st_reg.trap_pending_flag && !seq.clear_trap_pending_instr |=> st_reg.trap_pending_flag;
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("trap flag cleared wrongly");
    property p_gie_kept;
        @(posedge sys_clk) disable iff (!reset_n)
            trap_now && !seq.return_from_irq_instr |=> global_irq_enable == $past(global_irq_enable);
    endproperty
    a_gie_kept: assert property (p_gie_kept) else $error("trap changed global enable");
    property p_block;
        @(posedge sys_clk) disable iff (!reset_n) st_reg.trap_pending_flag |-> !irq_request;
    endproperty
    a_block: assert property (p_block) else $error("maskable during trap");
    property p_vec_trap;
        @(posedge sys_clk) disable iff (!reset_n)
            seq.vector_select_instr && st_reg.trap_pending_flag |=> vector_valid && vector_low == 8'hfe;
    endproperty
    a_vec_trap: assert property (p_vec_trap) else $error("wrong trap vector");
    property p_ret_addr;
        @(posedge sys_clk) disable iff (!reset_n) trap_now |=> return_addr == $past(seq.fetch_pc);
    endproperty
    a_ret_addr: assert property (p_ret_addr) else $error("bad return address");
    property p_return_from_irq_instr;
        @(posedge sys_clk) disable iff (!reset_n)
            seq.return_from_irq_instr && !trap_now && !irq_request |=> global_irq_enable;
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return did not set enable");
    property p_wake_latch;
        @(posedge sys_clk) disable iff (!reset_n) wake_edge[0] |=> st_reg.wake_pending_reg[0];
    endproperty
    a_wake_latch: assert property (p_wake_latch) else $error("wake edge lost");
    property p_nest;
        @(posedge sys_clk) disable iff (!reset_n) st_reg.ctx != twi_pkg::TWI_IDLE |-> !irq_request;
    endproperty
    a_nest: assert property (p_nest) else $error("maskable nested");
endmodule

/* bench/twi_seq_model.sv */
// Purpose: sequencer and program memory stand-in
// Assumes: one-cycle instruction pulses launched after a rising edge
// Notes: memory bus shows the inverse byte once a fetch is over
module twi_seq_model (
    input wire logic sys_clk,
    output twi_pkg::twi_seq_s seq,
    output logic [7:0] prog_mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        seq = '0;
        prog_mem_data = 8'ha5;
    end
    task automatic pulse(input twi_pkg::twi_seq_s s, input logic [7:0] d);
        @(posedge sys_clk);
        seq <= s;
        prog_mem_data <= d;
        @(posedge sys_clk);
        seq <= '0;
        // Stale byte would hide a decode that ignores the strobe
        prog_mem_data <= ~d;
    endtask
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the trap and wake block
// Assumes: zero-wait APB, sequencer pulses from the model
// Notes: each scenario starts from a fresh reset
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    twi_pkg::twi_apb_req_s apb_req = '0;
    twi_pkg::twi_seq_s seq;
    logic [7:0] prog_mem_data, fetched_opcode, vector_low, wake_pins = 8'h00;
    logic ext_pin = 1'b0;
    logic halted = 1'b0;
    logic [31:0] prdata, rdata;
    logic [14:0] return_addr, pc_load_value;
    logic pready, pslverr, trap_ack, irq_request, vector_valid, push_valid;
    logic pc_load_valid, resume_after_halt, global_irq_enable;
    int n_fail = 0;
    int checks_done = 0;

    always #20 sys_clk = ~sys_clk;

    twi_seq_model u_twi_seq_model (.sys_clk(sys_clk), .seq(seq), .prog_mem_data(prog_mem_data));

    twi_trap_wake_irq u_twi_trap_wake_irq (
        .sys_clk(sys_clk), .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seq(seq), .prog_mem_data(prog_mem_data), .wake_pins(wake_pins),
        .ext_pin(ext_pin), .halted(halted), .fetched_opcode(fetched_opcode), .trap_ack(trap_ack),
        .irq_request(irq_request), .vector_low(vector_low), .vector_valid(vector_valid),
        .return_addr(return_addr), .push_valid(push_valid), .pc_load_valid(pc_load_valid),
        .pc_load_value(pc_load_value), .resume_after_halt(resume_after_halt),
        .global_irq_enable(global_irq_enable)
    );

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdata = prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdata);
    endtask

    task op(input twi_pkg::twi_seq_s s, input logic [7:0] d);
        u_twi_seq_model.pulse(s, d);
        #1;
    endtask

    task trap_fetch(input logic [14:0] pc);
        op('{fetch_valid:1'b1, fetch_in_range:1'b1, fetch_pc:pc, default:'0}, twi_pkg::TRAP_OPCODE);
    endtask

    task do_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        wake_pins <= 8'h00;
        ext_pin <= 1'b0;
        halted <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask

    task t_trap;
        do_reset;
        rd(twi_pkg::OFF_STATUS, 32'h0, "status after reset");
        rd(8'h14, 32'h0, "unmapped read");
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h1);
        op('{fetch_valid:1'b1, fetch_in_range:1'b1, default:'0}, 8'h3c);
        chk("trap_ack nonzero opcode", 32'h0, trap_ack);
        trap_fetch(15'h1234);
        chk("trap_ack", 32'h1, trap_ack);
        chk("push_valid", 32'h1, push_valid);
        chk("return_addr", 32'h1234, return_addr);
        chk("global_irq_enable", 32'h1, global_irq_enable);
        op('{vector_select_instr:1'b1, default:'0}, 8'h5a);
        chk("vector_low trap", twi_pkg::VEC_TRAP, vector_low);
        chk("vector_valid", 32'h1, vector_valid);
        op('{fetch_valid:1'b1, fetch_pc:15'h7fff, default:'0}, 8'h3c);
        chk("trap_ack unused memory", 32'h1, trap_ack);
    endtask

    task t_mask;
        do_reset;
        apb(1'b1, twi_pkg::OFF_WAKE_EDGE, 32'h1);
        apb(1'b1, twi_pkg::OFF_WAKE_ENABLE, 32'h1);
        trap_fetch(15'h0010);
        @(posedge sys_clk);
        wake_pins <= 8'h01;
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h2);
        op('{return_from_irq_instr:1'b1, default:'0}, 8'h5a);
        chk("global_irq_enable after return", 32'h1, global_irq_enable);
        chk("irq_request trap pending", 32'h0, irq_request);
        op('{clear_trap_pending_instr:1'b1, default:'0}, 8'h5a);
        chk("irq_request after clear", 32'h1, irq_request);
        @(posedge sys_clk);
        #1;
        chk("push_valid maskable", 32'h1, push_valid);
        chk("global_irq_enable taken", 32'h0, global_irq_enable);
        op('{vector_select_instr:1'b1, default:'0}, 8'h5a);
        chk("vector_low wake", twi_pkg::VEC_WAKE, vector_low);
        rd(twi_pkg::OFF_STATUS, 32'h1, "status in maskable");
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h3);
        chk("irq_request nested", 32'h0, irq_request);
        trap_fetch(15'h0200);
        chk("trap_ack preempt", 32'h1, trap_ack);
        op('{clear_trap_pending_instr:1'b1, default:'0}, 8'h5a);
        chk("irq_request in trap routine", 32'h0, irq_request);
    endtask

    task t_wake;
        do_reset;
        apb(1'b1, twi_pkg::OFF_WAKE_EDGE, 32'h2);
        @(posedge sys_clk);
        wake_pins <= 8'h03;
        rd(twi_pkg::OFF_WAKE_PENDING, 32'h2, "pending rising");
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h3);
        chk("irq_request pin disabled", 32'h0, irq_request);
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h2);
        apb(1'b1, twi_pkg::OFF_WAKE_ENABLE, 32'h2);
        chk("irq_request global off", 32'h0, irq_request);
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h3);
        chk("irq_request both on", 32'h1, irq_request);
        @(posedge sys_clk);
        wake_pins <= 8'h02;
        rd(twi_pkg::OFF_WAKE_PENDING, 32'h3, "pending falling");
        apb(1'b1, twi_pkg::OFF_WAKE_PENDING, 32'h1);
        rd(twi_pkg::OFF_WAKE_PENDING, 32'h1, "pending clear");
    endtask

    task t_ext;
        do_reset;
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h4);
        @(posedge sys_clk);
        ext_pin <= 1'b1;
        rd(twi_pkg::OFF_CONTROL, 32'h4, "ext rising ignored");
        @(posedge sys_clk);
        ext_pin <= 1'b0;
        rd(twi_pkg::OFF_CONTROL, 32'h14, "ext falling");
        op('{vector_select_instr:1'b1, default:'0}, 8'h5a);
        chk("vector_low ext", twi_pkg::VEC_EXT, vector_low);
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h0);
        op('{vector_select_instr:1'b1, default:'0}, 8'h5a);
        chk("vector_low default", twi_pkg::VEC_DEFAULT, vector_low);
    endtask

    task t_halt;
        do_reset;
        apb(1'b1, twi_pkg::OFF_WAKE_EDGE, 32'h1);
        apb(1'b1, twi_pkg::OFF_WAKE_ENABLE, 32'h1);
        @(posedge sys_clk);
        halted <= 1'b1;
        wake_pins <= 8'h01;
        @(posedge sys_clk);
        #1;
        chk("resume_after_halt irq off", 32'h1, resume_after_halt);
        @(posedge sys_clk);
        wake_pins <= 8'h00;
        apb(1'b1, twi_pkg::OFF_WAKE_PENDING, 32'h0);
        apb(1'b1, twi_pkg::OFF_CONTROL, 32'h3);
        chk("irq_request before wake", 32'h0, irq_request);
        @(posedge sys_clk);
        wake_pins <= 8'h01;
        @(posedge sys_clk);
        #1;
        chk("resume_after_halt irq on", 32'h0, resume_after_halt);
        chk("irq_request wake while halted", 32'h1, irq_request);
    endtask

    task t_stack;
        do_reset;
        op('{stack_pop:1'b1, stack_ptr:8'h70, default:'0}, 8'h5a);
        chk("pc_load_valid", 32'h1, pc_load_valid);
        chk("pc_load_value", twi_pkg::STACK_UNDERFLOW_PC, pc_load_value);
        op('{stack_pop:1'b1, stack_ptr:twi_pkg::STACK_LIMIT, default:'0}, 8'h5a);
        chk("pc_load_valid at limit", 32'h0, pc_load_valid);
    endtask

    initial
    begin
        t_trap;
        t_mask;
        t_wake;
        t_ext;
        t_halt;
        t_stack;
        print_verdict;
    end

    // Whole run is about 130 cycles
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        n_fail++;
        print_verdict;
    end
endmodule
